//--- dv/i2c_master_model.sv
// behavioural i2c bus master on the far side of the slave
`timescale 1ns/10ps

module i2c_master_model (
    // system
    input wire logic clock,
    // resolved wire levels
    input wire logic sclWire,
    input wire logic sdaWire,
    // open-drain pull-downs, high pulls the wire low
    output logic sclLow,
    output logic sdaLow
);
    initial begin
        sclLow = 1'h0;
        sdaLow = 1'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // the slave may hold a released clock low for as long as it likes
    task automatic rise();
        sclLow <= 1'h0;
        tick(1);
        while (!sclWire) tick(1);
        tick(1);
    endtask

    // one bit, falling edge to falling edge, 8 clocks unstretched
    task automatic bitx(input logic b, output logic s);
        tick(2);
        sdaLow <= ~b;
        tick(3);
        rise();
        s = sdaWire;
        tick(1);
        sclLow <= 1'h1;
    endtask

    // ack low means the slave took the byte
    task automatic writeByte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(v[i], s);
        bitx(1'h1, ack);
    endtask

    task automatic readByte(input logic nack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'h1, v[i]);
        bitx(nack, s);
    endtask

    // also serves as a repeated start with the clock low
    task automatic start();
        tick(2);
        sdaLow <= 1'h0;
        tick(3);
        rise();
        tick(1);
        sdaLow <= 1'h1;
        tick(3);
        sclLow <= 1'h1;
    endtask

    task automatic stop();
        tick(2);
        sdaLow <= 1'h1;
        tick(3);
        rise();
        tick(1);
        sdaLow <= 1'h0;
        tick(4);
    endtask
endmodule // i2c_master_model

//--- dv/i2c_slave_addr_ack_checker.sv
// port-level assertions for the i2c slave address and acknowledge block
`timescale 1ns/10ps

module i2c_slave_addr_ack_checker
    import i2c_slave_addr_ack_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic rst,
    // pins
    input wire logic busClockPinIn,
    input wire logic busDataPinIn,
    input wire logic busClockPinOut,
    input wire logic busClockPinOe,
    input wire logic busDataPinOut,
    // software side
    input wire ctrl_t ctrl,
    input wire logic addrWrite,
    input wire logic bufferRead,
    input wire status_t status,
    input wire logic [7:0] shiftBufferReg
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_start;
        $fell(busDataPinIn) && busClockPinIn;
    endsequence
    sequence s_stretch;
        $rose(busClockPinOe);
    endsequence

    property p_open_drain;
        !busClockPinOut && !busDataPinOut;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin driven high");

    property p_ack_timing_hold;
        $rose(status.ackTimingFlag) |->
            $past(ctrl.addressHoldEnable) || $past(ctrl.dataHoldEnable);
    endproperty
    a_ack_timing_hold: assert property (p_ack_timing_hold)
        else $error("ack timing set with holds off");

    // a stretch must have a reason visible to software
    property p_stretch_cause;
        s_stretch |-> ##[0:2]
            (status.updateAddressFlag || status.ackTimingFlag);
    endproperty
    a_stretch_cause: assert property (p_stretch_cause)
        else $error("clock stretched without a flag");

    property p_update_stretch;
        $rose(status.updateAddressFlag) |-> ##[0:2] busClockPinOe;
    endproperty
    a_update_stretch: assert property (p_update_stretch)
        else $error("update address without stretch");

    property p_update_release;
        addrWrite && status.updateAddressFlag |=> ##[0:1]
            (!status.updateAddressFlag && !busClockPinOe);
    endproperty
    a_update_release: assert property (p_update_release)
        else $error("address write did not release");

    property p_load_sets_full;
        $changed(shiftBufferReg) |-> status.bufferFullFlag;
    endproperty
    a_load_sets_full: assert property (p_load_sets_full)
        else $error("buffer loaded without full flag");

    property p_read_clears_full;
        bufferRead ##1 $stable(shiftBufferReg) |-> !status.bufferFullFlag;
    endproperty
    a_read_clears_full: assert property (p_read_clears_full)
        else $error("buffer read left full flag");

    property p_overflow_cause;
        $rose(status.receiveOverflowFlag) |-> $past(status.bufferFullFlag);
    endproperty
    a_overflow_cause: assert property (p_overflow_cause)
        else $error("overflow without full buffer");

    property p_start_event;
        (ctrl.portModeSelect == MODE_SLAVE7_SS) and s_start |->
            ##[1:6] status.serialEventFlag;
    endproperty
    a_start_event: assert property (p_start_event)
        else $error("start gave no event");
endmodule // i2c_slave_addr_ack_checker

bind i2c_slave_addr_ack i2c_slave_addr_ack_checker u_chk (
    .clock, .rst, .busClockPinIn, .busDataPinIn, .busClockPinOut,
    .busClockPinOe, .busDataPinOut, .ctrl, .addrWrite, .bufferRead,
    .status, .shiftBufferReg
);

//--- dv/i2c_slave_addr_ack_tb.sv
// self-checking bench for the i2c slave address and acknowledge block
`timescale 1ns/10ps

module i2c_slave_addr_ack_tb
    import i2c_slave_addr_ack_pkg::*;
;
    logic clock = 1'h0;
    logic rst = 1'h1;
    ctrl_t ctrl = '0;
    // strobes: address write, buffer read, overflow, event, hold release
    logic [4:0] sw = '0;
    logic [7:0] addrWriteData = 8'h00;
    logic [7:0] txData = 8'h96;
    logic sclLow;
    logic sdaLow;
    logic sclOe;
    logic sdaOe;
    logic sclOut;
    logic sdaOut;
    wire logic sclWire;
    wire logic sdaWire;
    status_t status;
    logic [7:0] shiftBufferReg;
    logic [7:0] slaveAddressReg;
    logic a;
    logic [7:0] d;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    // pull-ups: a released wire reads high
    assign sclWire = ~sclLow & ~(sclOe & ~sclOut);
    assign sdaWire = ~sdaLow & ~(sdaOe & ~sdaOut);

    always #50 clock = ~clock;

    i2c_master_model u_master (.clock, .sclWire, .sdaWire, .sclLow, .sdaLow);

    i2c_slave_addr_ack u_dut (
        .clock, .rst, .busClockPinIn(sclWire), .busClockPinOut(sclOut),
        .busClockPinOe(sclOe), .busDataPinIn(sdaWire), .busDataPinOut(sdaOut),
        .busDataPinOe(sdaOe), .ctrl, .addrWrite(sw[0]), .addrWriteData,
        .bufferRead(sw[1]), .overflowClear(sw[2]), .eventClear(sw[3]),
        .holdRelease(sw[4]), .txData, .status, .shiftBufferReg,
        .slaveAddressReg
    );

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: bit %b, want %b", $time, got, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask

    task pulse(input int i);
        @(posedge clock);
        sw[i] <= 1'h1;
        @(posedge clock);
        sw[i] <= 1'h0;
        @(posedge clock);
    endtask

    task wrAddr(input logic [7:0] v);
        addrWriteData <= v;
        pulse(0);
    endtask

    task automatic summarize();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // whole run is under two thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'h0;
        ctrl.portModeSelect <= MODE_SLAVE7;
        repeat (4) @(posedge clock);
        chk8({2'h0, status}, 8'h00);
        chk8(slaveAddressReg, SLAVE_ADDR_RESET);
        wrAddr(8'h52);
        chk8(slaveAddressReg, 8'h52);
        u_master.start();
        u_master.writeByte(8'h52, a);
        chk1(a, 1'h0);
        chk8(shiftBufferReg, 8'h52);
        chk1(status.bufferFullFlag, 1'h1);
        chk1(status.serialEventFlag, 1'h1);
        chk1(status.ackTimingFlag, 1'h0);
        pulse(1);
        u_master.writeByte(8'ha5, a);
        chk1(a, 1'h0);
        chk8(shiftBufferReg, 8'ha5);
        u_master.stop();
        pulse(1);
        pulse(3);
        u_master.start();
        u_master.writeByte(8'h60, a);
        chk1(a, 1'h1);
        u_master.stop();
        chk8({2'h0, status}, 8'h00);
        chk8(shiftBufferReg, 8'ha5);
        u_master.start();
        u_master.writeByte(8'h52, a);
        u_master.writeByte(8'h3c, a);
        chk1(a, 1'h1);
        chk1(status.receiveOverflowFlag, 1'h1);
        u_master.stop();
        pulse(1);
        pulse(2);
        pulse(3);
        u_master.start();
        u_master.writeByte(8'h53, a);
        chk1(a, 1'h0);
        u_master.readByte(1'h0, d);
        @(posedge clock);
        chk8(d, 8'h96);
        chk1(status.ackStatusFlag, 1'h0);
        u_master.readByte(1'h1, d);
        @(posedge clock);
        chk1(status.ackStatusFlag, 1'h1);
        u_master.stop();
        pulse(1);
        pulse(3);
        ctrl.portModeSelect <= MODE_SLAVE7_SS;
        u_master.start();
        repeat (3) @(posedge clock);
        chk1(status.serialEventFlag, 1'h1);
        pulse(3);
        u_master.writeByte(8'h60, a);
        u_master.stop();
        repeat (6) @(posedge clock);
        chk1(status.serialEventFlag, 1'h1);
        pulse(3);
        ctrl.portModeSelect <= MODE_SLAVE7;
        ctrl.addressHoldEnable <= 1'h1;
        for (int v = 0; v < 2; v++) begin
            ctrl.ackDataValue <= v[0];
            pulse(1);
            u_master.start();
            fork
                u_master.writeByte(8'h52, a);
                begin
                    while (!status.ackTimingFlag) @(posedge clock);
                    @(posedge clock);
                    chk1(sclOe, 1'h1);
                    pulse(4);
                end
            join
            chk1(a, v[0]);
            // flag drops once the ninth fall has passed the synchroniser
            repeat (4) @(posedge clock);
            chk1(status.ackTimingFlag, 1'h0);
            u_master.stop();
        end
        ctrl.addressHoldEnable <= 1'h0;
        // low byte mismatch first, then a full match left open
        for (int k = 1; k >= 0; k--) begin
            ctrl.portModeSelect <= k ? MODE_SLAVE10_SS : MODE_SLAVE10;
            wrAddr(8'h06);
            pulse(1);
            u_master.start();
            u_master.writeByte(8'hf6, a);
            chk1(a, 1'h0);
            repeat (6) @(posedge clock);
            chk1(status.updateAddressFlag, 1'h1);
            chk1(sclOe, 1'h1);
            wrAddr(8'h34);
            chk1(status.updateAddressFlag, 1'h0);
            pulse(1);
            pulse(3);
            u_master.writeByte(8'h34 + k[7:0], a);
            chk1(a, k[0]);
            repeat (6) @(posedge clock);
            chk1(status.serialEventFlag, 1'h1);
            chk1(status.updateAddressFlag, 1'h1);
            chk1(sclOe, 1'h1);
            wrAddr(8'h06);
            if (k != 0) u_master.stop();
        end
        chk8(shiftBufferReg, 8'h34);
        pulse(1);
        u_master.start();
        u_master.writeByte(8'hf7, a);
        chk1(a, 1'h0);
        u_master.readByte(1'h1, d);
        chk8(d, 8'h96);
        u_master.stop();
        u_master.start();
        u_master.writeByte(8'hf7, a);
        chk1(a, 1'h1);
        u_master.stop();
        summarize();
    end
endmodule // i2c_slave_addr_ack_tb

//--- logic/i2c_slave_addr_ack.sv
// i2c slave: address recognition, acknowledge generation, clock stretching
`timescale 1ns/10ps

module i2c_slave_addr_ack
    import i2c_slave_addr_ack_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic rst,
    // bus clock pin, open drain
    input wire logic busClockPinIn,
    output logic busClockPinOut,
    output logic busClockPinOe,
    // bus data pin, open drain
    input wire logic busDataPinIn,
    output logic busDataPinOut,
    output logic busDataPinOe,
    // software control
    input wire ctrl_t ctrl,
    input wire logic addrWrite,
    input wire logic [7:0] addrWriteData,
    input wire logic bufferRead,
    input wire logic overflowClear,
    input wire logic eventClear,
    input wire logic holdRelease,
    input wire logic [7:0] txData,
    // software status
    output status_t status,
    output logic [7:0] shiftBufferReg,
    output logic [7:0] slaveAddressReg
);

    logic [SYNC_STAGES-1:0] sclSync_r;
    logic [SYNC_STAGES-1:0] sdaSync_r;
    logic sclPrev_r;
    logic sdaPrev_r;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic byteDone;
    logic ackEnd;
    logic ackRise;

    phase_t phase_r;
    logic [3:0] bitCnt_r;
    logic [7:0] rxShift_r;
    logic [7:0] txShift_r;
    logic [7:0] slaveAddr_r;
    logic [7:0] buffer_r;
    logic matched10_r;
    logic ackThis_r;
    logic softAckWait_r;
    logic uaPending_r;
    logic nextTx_r;
    logic skipFall_r;
    logic sclOe_r;
    logic sdaOe_r;
    logic bf_r;
    logic ov_r;
    logic ack_status_flag_r;
    logic ack_timing_flag_r;
    logic ua_r;
    logic event_r;

    logic ssMode;
    logic tenBit;
    logic [7:0] rxByte;
    logic match7;
    logic hiMatch;
    logic loMatch;
    logic addrPhase;
    logic holdThis;
    logic hwAck;
    logic takeByte;
    logic goTx;
    logic goRx;
    logic goLo;

    // pins pass two flops before any logic looks at them
    always_ff @(posedge clock) begin
        if (rst) begin
            sclSync_r <= '1;
            sdaSync_r <= '1;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            sclSync_r <= {sclSync_r[SYNC_STAGES-2:0], busClockPinIn};
            sdaSync_r <= {sdaSync_r[SYNC_STAGES-2:0], busDataPinIn};
            sclPrev_r <= sclSync_r[SYNC_STAGES-1];
            sdaPrev_r <= sdaSync_r[SYNC_STAGES-1];
        end
    end

    assign sclRise = sclSync_r[SYNC_STAGES-1] & ~sclPrev_r;
    assign sclFall = ~sclSync_r[SYNC_STAGES-1] & sclPrev_r;
    assign startSeen = sclPrev_r & sclSync_r[SYNC_STAGES-1]
                       & sdaPrev_r & ~sdaSync_r[SYNC_STAGES-1];
    assign stopSeen = sclPrev_r & sclSync_r[SYNC_STAGES-1]
                      & ~sdaPrev_r & sdaSync_r[SYNC_STAGES-1];

    // eighth falling edge ends the byte; ninth ends the ack slot
    assign byteDone = sclFall & (bitCnt_r == BIT_LAST_DATA)
                      & (phase_r != PH_IDLE);
    assign ackEnd = sclFall & (bitCnt_r == BIT_ACK_SLOT)
                    & (phase_r != PH_IDLE);
    assign ackRise = sclRise & (bitCnt_r == BIT_ACK_SLOT);

    // mode decode
    assign ssMode = (ctrl.portModeSelect == MODE_SLAVE7_SS)
                    | (ctrl.portModeSelect == MODE_SLAVE10_SS);
    assign tenBit = (ctrl.portModeSelect == MODE_SLAVE10)
                    | (ctrl.portModeSelect == MODE_SLAVE10_SS);

    // the byte including the bit sampled on the eighth rising edge
    assign rxByte = rxShift_r;
    assign match7 = rxByte[7:1] == slaveAddr_r[7:1];
    assign hiMatch = (rxByte[7:3] == TEN_BIT_PREFIX)
                     & (rxByte[2:1] == slaveAddr_r[ADDR_HI_MSB:ADDR_HI_LSB]);
    assign loMatch = rxByte == slaveAddr_r;

    // byte classification at the end of a byte
    always_comb begin
        goTx = 1'b0;
        goRx = 1'b0;
        goLo = 1'b0;
        unique case (phase_r)
            PH_ADDR: begin
                if (!tenBit) begin
                    goTx = match7 & rxByte[0];
                    goRx = match7 & ~rxByte[0];
                end else begin
                    goLo = hiMatch & ~rxByte[0];
                    // read only after a full 10-bit write match
                    goTx = hiMatch & rxByte[0] & matched10_r;
                end
            end
            PH_ADDR_LO: goRx = loMatch;
            PH_RX: goRx = 1'b1;
            PH_TX: goTx = 1'b0;
            PH_IDLE: goRx = 1'b0;
        endcase
    end

    assign addrPhase = (phase_r == PH_ADDR) | (phase_r == PH_ADDR_LO);
    assign takeByte = goTx | goRx | goLo;
    assign holdThis = addrPhase ? ctrl.addressHoldEnable
                                : ctrl.dataHoldEnable;
    // automatic ack refused while buffer full or overflowed, except for a read address or a 10-bit high byte
    assign hwAck = takeByte & ~((phase_r == PH_RX) & (bf_r | ov_r))
                   & ~(goRx & (phase_r != PH_RX) & (bf_r | ov_r));

    // slave address register; software write releases the update hold
    always_ff @(posedge clock) begin
        if (rst) begin
            slaveAddr_r <= SLAVE_ADDR_RESET;
        end else if (addrWrite) begin
            slaveAddr_r <= addrWriteData;
        end
    end

    // the clock fall that closes a start is not a data bit
    always_ff @(posedge clock) begin
        if (rst) begin
            skipFall_r <= 1'b0;
        end else if (startSeen) begin
            skipFall_r <= 1'b1;
        end else if (sclFall) begin
            skipFall_r <= 1'b0;
        end
    end

    // bus phase and bit counting
    always_ff @(posedge clock) begin
        if (rst) begin
            phase_r <= PH_IDLE;
            bitCnt_r <= 4'h0;
            rxShift_r <= BYTE_RESET;
            matched10_r <= 1'b0;
            nextTx_r <= 1'b0;
        end else if (startSeen) begin
            phase_r <= PH_ADDR;
            bitCnt_r <= 4'h0;
        end else if (stopSeen) begin
            phase_r <= PH_IDLE;
            bitCnt_r <= 4'h0;
            matched10_r <= 1'b0;
        end else begin
            if (sclRise && bitCnt_r < BIT_ACK_SLOT) begin
                rxShift_r <= {rxShift_r[6:0], sdaSync_r[SYNC_STAGES-1]};
            end
            if (byteDone) begin
                bitCnt_r <= BIT_ACK_SLOT;
                nextTx_r <= goTx;
                // a low address byte ends only after its ack slot
                if (!takeByte && phase_r != PH_TX
                    && phase_r != PH_ADDR_LO) begin
                    phase_r <= PH_IDLE; // silent on mismatch
                end
                if (phase_r == PH_ADDR_LO) begin
                    matched10_r <= loMatch;
                end
            end else if (ackEnd) begin
                bitCnt_r <= 4'h0;
                if (phase_r == PH_TX) begin
                    // master nack ends the read
                    phase_r <= ack_status_flag_r ? PH_IDLE : PH_TX;
                end else if (phase_r == PH_ADDR_LO && !matched10_r) begin
                    phase_r <= PH_IDLE;
                end else if (phase_r == PH_ADDR && tenBit && !nextTx_r) begin
                    phase_r <= PH_ADDR_LO;
                end else begin
                    phase_r <= nextTx_r ? PH_TX : PH_RX;
                end
            end else if (sclFall && !skipFall_r
                         && bitCnt_r < BIT_LAST_DATA) begin
                bitCnt_r <= bitCnt_r + 4'h1;
            end
        end
    end

    // acknowledge decision and software hold of the ack slot
    always_ff @(posedge clock) begin
        if (rst) begin
            ackThis_r <= 1'b0;
            softAckWait_r <= 1'b0;
        end else if (startSeen || stopSeen) begin
            ackThis_r <= 1'b0;
            softAckWait_r <= 1'b0;
        end else if (byteDone && phase_r != PH_TX) begin
            ackThis_r <= hwAck;
            // software chooses the level when holding
            softAckWait_r <= takeByte & holdThis;
        end else if (holdRelease && softAckWait_r) begin
            softAckWait_r <= 1'b0;
        end
    end

    // data pin drive: ack low, or transmit bits; released in tx ack slot
    always_ff @(posedge clock) begin
        if (rst) begin
            sdaOe_r <= 1'b0;
            txShift_r <= BYTE_RESET;
        end else if (startSeen || stopSeen) begin
            sdaOe_r <= 1'b0;
        end else if (byteDone) begin
            if (phase_r == PH_TX) begin
                sdaOe_r <= 1'b0; // release for the master's ack
            end else begin
                // hardware ack unless software holds the slot
                sdaOe_r <= hwAck & ~holdThis;
            end
        end else if (holdRelease && softAckWait_r) begin
            sdaOe_r <= ~ctrl.ackDataValue;
        end else if (ackEnd) begin
            if ((nextTx_r && phase_r != PH_TX)
                || (phase_r == PH_TX && !ack_status_flag_r)) begin
                txShift_r <= txData;
                sdaOe_r <= ~txData[7];
            end else begin
                sdaOe_r <= 1'b0;
            end
        end else if (sclFall && phase_r == PH_TX
                     && bitCnt_r < BIT_LAST_DATA) begin
            txShift_r <= {txShift_r[6:0], 1'b0};
            sdaOe_r <= ~txShift_r[6];
        end
    end

    // clock stretch: software ack hold, or until address rewrite
    always_ff @(posedge clock) begin
        if (rst) begin
            uaPending_r <= 1'b0;
        end else if (startSeen || stopSeen) begin
            uaPending_r <= 1'b0;
        end else if (byteDone) begin
            // high byte matched, or low byte seen in any case
            uaPending_r <= goLo | (phase_r == PH_ADDR_LO);
        end else if (ackEnd) begin
            uaPending_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sclOe_r <= 1'b0;
        end else if (byteDone && takeByte && holdThis
                     && phase_r != PH_TX) begin
            sclOe_r <= 1'b1;
        end else if (holdRelease && softAckWait_r) begin
            sclOe_r <= 1'b0;
        end else if (ackEnd && uaPending_r) begin
            sclOe_r <= 1'b1; // hold until slave address is rewritten
        end else if (addrWrite && ua_r) begin
            sclOe_r <= 1'b0;
        end
    end

    // update address flag; a new setting wins over a same-cycle write
    always_ff @(posedge clock) begin
        if (rst) begin
            ua_r <= 1'b0;
        end else if (ackEnd && uaPending_r) begin
            ua_r <= 1'b1;
        end else if (addrWrite) begin
            ua_r <= 1'b0;
        end
    end

    // receive buffer and its flags
    always_ff @(posedge clock) begin
        if (rst) begin
            buffer_r <= BYTE_RESET;
        end else if (byteDone && takeByte && phase_r != PH_TX) begin
            buffer_r <= rxByte;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bf_r <= 1'b0;
        end else if (byteDone && takeByte && phase_r != PH_TX) begin
            bf_r <= 1'b1;
        end else if (bufferRead) begin
            bf_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ov_r <= 1'b0;
        end else if (byteDone && takeByte && phase_r != PH_TX && bf_r) begin
            ov_r <= 1'b1;
        end else if (overflowClear) begin
            ov_r <= 1'b0;
        end
    end

    // master's ack level while the device transmits
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_status_flag_r <= 1'b0;
        end else if (ackRise && phase_r == PH_TX) begin
            ack_status_flag_r <= sdaSync_r[SYNC_STAGES-1];
        end
    end

    // ack timing flag, only with a hold enable set
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_timing_flag_r <= 1'b0;
        end else if (byteDone && (takeByte || phase_r == PH_TX)
                     && (ctrl.addressHoldEnable || ctrl.dataHoldEnable)) begin
            ack_timing_flag_r <= 1'b1;
        end else if (ackEnd || startSeen || stopSeen) begin
            ack_timing_flag_r <= 1'b0;
        end
    end

    // serial event flag; set wins over software clear
    always_ff @(posedge clock) begin
        if (rst) begin
            event_r <= 1'b0;
        end else if ((byteDone && takeByte && !goLo)
                     || (byteDone && phase_r == PH_ADDR_LO)) begin
            event_r <= 1'b1;
        end else if (ackEnd && phase_r == PH_TX && !ack_status_flag_r) begin
            event_r <= 1'b1; // next transmit byte wanted
        end else if (ssMode && (startSeen || stopSeen)) begin
            event_r <= 1'b1;
        end else if (eventClear) begin
            event_r <= 1'b0;
        end
    end

    // open-drain pins only ever pull low
    always_ff @(posedge clock) begin
        if (rst) begin
            busClockPinOut <= 1'b0;
            busDataPinOut <= 1'b0;
        end else begin
            busClockPinOut <= 1'b0;
            busDataPinOut <= 1'b0;
        end
    end

    assign busClockPinOe = sclOe_r;
    assign busDataPinOe = sdaOe_r;
    assign shiftBufferReg = buffer_r;
    assign slaveAddressReg = slaveAddr_r;
    assign status = '{bufferFullFlag: bf_r,
                      receiveOverflowFlag: ov_r,
                      ackStatusFlag: ack_status_flag_r,
                      ackTimingFlag: ack_timing_flag_r,
                      updateAddressFlag: ua_r,
                      serialEventFlag: event_r};

endmodule // i2c_slave_addr_ack

//--- logic/i2c_slave_addr_ack_pkg.sv
// shared constants and types for the i2c slave address and acknowledge block
package i2c_slave_addr_ack_pkg;

    // port mode select encodings
    localparam logic [3:0] MODE_SLAVE7 = 4'h6;
    localparam logic [3:0] MODE_SLAVE10 = 4'h7;
    localparam logic [3:0] MODE_SLAVE7_SS = 4'he;
    localparam logic [3:0] MODE_SLAVE10_SS = 4'hf;

    // 10-bit high byte prefix, bits 7..3 of the first byte
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
    // position of the two top address bits in the slave address register
    localparam int ADDR_HI_MSB = 2;
    localparam int ADDR_HI_LSB = 1;

    // falling edges counted within a byte
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK_SLOT = 4'h8;

    // reset values
    localparam logic [7:0] SLAVE_ADDR_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // synchroniser depth before any logic reads a pin
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ADDR = 3'b001,
        PH_ADDR_LO = 3'b010,
        PH_RX = 3'b011,
        PH_TX = 3'b100
    } phase_t;

    // software control bits
    typedef struct packed {
        logic [3:0] portModeSelect;
        logic addressHoldEnable;
        logic dataHoldEnable;
        logic ackDataValue;
    } ctrl_t;

    // status bits seen by software
    typedef struct packed {
        logic bufferFullFlag;
        logic receiveOverflowFlag;
        logic ackStatusFlag;
        logic ackTimingFlag;
        logic updateAddressFlag;
        logic serialEventFlag;
    } status_t;

endpackage
